// ---- common/cosc_params.svh ----
// Register offsets, field positions, reset values, masks and special codes for the startup option block
`ifndef COSC_PARAMS_SVH
`define COSC_PARAMS_SVH
`define COSC_OFF_PRIMARY     12'h000
`define COSC_OFF_SECONDARY   12'h004
`define COSC_OFF_CONTROL     12'h008
`define COSC_OFF_STATUS      12'h00C
`define COSC_PRIMARY_RESET   32'h0000_3FEC
`define COSC_SECONDARY_RESET 32'h0000_0000
`define COSC_PRIMARY_MASK    32'h1BFF_FFFF
`define COSC_SECONDARY_MASK  32'h0002_030F
`define COSC_BIT_CRC_BYPASS  28
`define COSC_BIT_SLEEP_SEL   27
`define COSC_BIT_DONE_PIPE   25
`define COSC_BIT_DRIVE_DONE  24
`define COSC_BIT_SINGLE      23
`define COSC_OSC_HI          22
`define COSC_OSC_LO          17
`define COSC_SRC_HI          16
`define COSC_SRC_LO          15
`define COSC_DONE_LO         12
`define COSC_MATCH_LO        9
`define COSC_LOCK_LO         6
`define COSC_GTS_LO          3
`define COSC_GWE_LO          0
`define COSC_BIT_KEEP_REL    17
`define COSC_BIT_RB_NOPIN    9
`define COSC_BIT_RB_EN       8
`define COSC_FLASH_RD_LO     2
`define COSC_FLASH_PG_LO     0
`define COSC_CRC_SPECIAL     16'hDEFC
`define COSC_CODE_KEEP       3'h7
`define COSC_CODE_TRACK      3'h6
`endif

// ---- common/cosc_pkg.sv ----
// Types shared by the startup option block
package cosc_pkg;
	typedef enum logic [1:0] {
		COSC_SRC_CONFIG,
		COSC_SRC_USER,
		COSC_SRC_TEST
	} cosc_src_t;
endpackage

// ---- common/cosc_seq_if.sv ----
// Option fields and status passed from the register bank to the sequencer, phase and release outputs passed back
`timescale 1ns/1ps
interface cosc_seq_if;
	logic [2:0] done_code;
	logic [2:0] match_code;
	logic [2:0] lock_code;
	logic [2:0] gts_code;
	logic [2:0] gwe_code;
	logic       done_pipe;
	logic       step_en;
	logic       finished_input;
	logic       match_ok;
	logic       lock_ok;
	logic [2:0] phase_gray;
	logic       done_release;
	logic       io_tristate;
	logic       write_enable;
	logic       end_of_startup;
	modport bank (output done_code, match_code, lock_code, gts_code, gwe_code, done_pipe, step_en,
		finished_input, match_ok, lock_ok, input phase_gray, done_release, io_tristate, write_enable,
		end_of_startup);
	modport seq (input done_code, match_code, lock_code, gts_code, gwe_code, done_pipe, step_en,
		finished_input, match_ok, lock_ok, output phase_gray, done_release, io_tristate, write_enable,
		end_of_startup);
endinterface

// ---- rtl/cosc_sequencer.sv ----
// Startup phase sequencer: eight Gray-coded phases, stalls and release points
`timescale 1ns/1ps
`include "cosc_params.svh"
module cosc_sequencer (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic reset,
	// Options and status
	cosc_seq_if.seq   sq
);
	import cosc_pkg::*;

	logic [2:0] phase_q;
	logic       fin_pipe_q;
	logic       fin_seen;
	logic       stall;
	logic       done_rel;

	function automatic logic [2:0] to_gray(input logic [2:0] b);
		return b ^ (b >> 1);
	endfunction

	// A phase field code n releases on reaching phase n+1
	function automatic logic reached(input logic [2:0] code, input logic [2:0] ph);
		return (code < `COSC_CODE_TRACK) && (ph >= code + 3'd1);
	endfunction

	always_ff @(posedge mclk) begin
		if (reset) begin
			fin_pipe_q <= 1'b0;
		end else if (sq.step_en) begin
			fin_pipe_q <= sq.finished_input;
		end
	end

	assign fin_seen = sq.done_pipe ? fin_pipe_q : sq.finished_input; // RULE3

	// Done code 110 still names phase 7; only the other release fields read it as track
	assign done_rel = (sq.done_code != `COSC_CODE_KEEP) && (phase_q >= sq.done_code + 3'd1); // RULE9

	// RULE10 RULE11 RULE19 RULE23
	assign stall = ((sq.match_code != `COSC_CODE_KEEP) && (phase_q == sq.match_code) && !sq.match_ok) ||
		((sq.lock_code != `COSC_CODE_KEEP) && (phase_q == sq.lock_code) && !sq.lock_ok);

	always_ff @(posedge mclk) begin
		if (reset) begin
			phase_q <= 3'h0;
		end else if (sq.step_en && !stall && phase_q != 3'h7) begin
			// Past the done release the sequencer waits for the pin to read back high
			if (!(done_rel && !fin_seen)) begin
				phase_q <= phase_q + 3'd1;
			end
		end
	end

	assign sq.phase_gray   = to_gray(phase_q); // RULE18
	assign sq.done_release = done_rel; // RULE9
	// RULE12 RULE22 RULE21
	assign sq.io_tristate  = (sq.gts_code == `COSC_CODE_TRACK) ? !fin_seen : !reached(sq.gts_code, phase_q);
	// RULE13 RULE20
	assign sq.write_enable = (sq.gwe_code == `COSC_CODE_TRACK) ? fin_seen : reached(sq.gwe_code, phase_q);
	assign sq.end_of_startup = (phase_q == 3'h7);

	a_gray_phase: assert property (@(posedge mclk) disable iff (reset) // RULE18
		$countones(sq.phase_gray ^ $past(sq.phase_gray)) <= 1)
		else $error("phase code moved by more than one bit");
	a_match_stall: assert property (@(posedge mclk) disable iff (reset) // RULE23
		(sq.match_code != 3'h7 && phase_q == sq.match_code && !sq.match_ok) |=> phase_q == $past(phase_q))
		else $error("sequencer left match stall early");
	a_lock_stall: assert property (@(posedge mclk) disable iff (reset) // RULE11
		(sq.lock_code != 3'h7 && phase_q == sq.lock_code && !sq.lock_ok) |=> phase_q == $past(phase_q))
		else $error("sequencer left lock stall early");
	a_gwe_keep: assert property (@(posedge mclk) disable iff (reset) // RULE13
		sq.gwe_code == 3'h7 |-> !sq.write_enable)
		else $error("write enable released under keep");
	a_gts_keep: assert property (@(posedge mclk) disable iff (reset) // RULE22
		sq.gts_code == 3'h7 |-> sq.io_tristate)
		else $error("three-state released under keep");
	a_done_keep: assert property (@(posedge mclk) disable iff (reset) // RULE9
		sq.done_code == 3'h7 |-> !sq.done_release)
		else $error("finished pin released under keep");
	a_gts_track: assert property (@(posedge mclk) disable iff (reset) // RULE12
		(sq.gts_code == 3'h6 && !sq.done_pipe) |-> sq.io_tristate == !sq.finished_input)
		else $error("three-state does not track finished pin");
endmodule

// ---- rtl/cosc_startup_options.sv ----
// APB register bank for the two startup option words and the startup sequencer around them
//
// Notes on behaviour
// [RULE1] Bypass bit skips CRC on special value
// [RULE2] Sleep select turns finished pin to status
// [RULE3] Pipeline bit adds stage on finished input
// [RULE4] Drive bit clear gives open-drain finished pin
// [RULE5] Non-single mode captures on every capture pulse
// [RULE6] Single mode needs capture-reset command between readbacks
// [RULE7] Six-bit field selects configuration clock rate
// [RULE8] Source field picks config, user or test clock
// [RULE9] Done field codes phases 1-7, 111 keeps
// [RULE10] Match field stalls phase 0-6, 111 none
// [RULE11] Lock field stalls phase 0-6, 111 none
// [RULE12] Three-state field phases 1-6, 110 tracks pin
// [RULE13] Write-enable field phases, tracks pin, or keeps
// [RULE14] Keep-release bit drops keep on unsync command
// [RULE15] Readback check enable, pin report unless disabled
// [RULE16] Flash first read takes one to four clocks
// [RULE17] Flash page length 1, 4, 8; 11 reserved
// [RULE18] Phases reported in Gray order
// [RULE19] Lock condition is AND of all locks
// [RULE20] Writes blocked until write enable asserted
// [RULE21] I/Os high impedance while three-state active
// [RULE22] Three-state code 111 keeps three-state asserted
// [RULE23] Stall holds phase until condition true
`timescale 1ns/1ps
`include "cosc_params.svh"
module cosc_startup_options #(
	parameter int NUM_CLOCK_MANAGERS = 4,
	parameter int NUM_IO_BANKS       = 4
) (
	// Clock and reset
	input  wire logic                          mclk,
	input  wire logic                          reset,
	// APB slave
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [11:0]                   paddr,
	input  wire logic [31:0]                   pwdata,
	output logic                               pready,
	output logic [31:0]                        prdata,
	output logic                               pslverr,
	// Startup clock ticks, one-cycle enables
	input  wire logic                          config_clock_tick,
	input  wire logic                          fabric_user_clock_tick,
	input  wire logic                          test_port_clock_tick,
	// Calibration and lock inputs
	input  wire logic [NUM_IO_BANKS-1:0]       impedance_calibration_match,
	input  wire logic [NUM_CLOCK_MANAGERS-1:0] clock_manager_lock,
	// Finished pin, three signals
	input  wire logic                          finished_pin_in,
	output logic                               finished_pin_out,
	output logic                               finished_pin_oe,
	// Global controls
	output logic                               global_io_tristate,
	output logic                               global_write_enable,
	output logic [2:0]                         startup_phase,
	// Configuration stream CRC
	input  wire logic                          crc_check_valid,
	input  wire logic [15:0]                   crc_check_value,
	output logic                               crc_check_skip,
	// Readback capture
	input  wire logic                          capture_input,
	input  wire logic                          global_capture_command,
	input  wire logic                          readback_capture_reset_command,
	output logic                               capture_strobe,
	// Readback check and keep
	input  wire logic                          readback_check_error,
	output logic                               readback_check_run,
	output logic                               init_pin_error,
	input  wire logic                          unsync_command,
	output logic                               config_port_keep,
	// Clock and flash option outputs
	output logic [5:0]                         osc_frequency_select,
	output logic [2:0]                         flash_first_read_clocks,
	output logic [3:0]                         flash_page_length,
	output logic                               flash_page_reserved
);
	import cosc_pkg::*;

	cosc_seq_if sq ();

	logic [31:0] primary_q;
	logic [31:0] secondary_q;
	logic        keep_q;
	logic        capture_armed_q;
	logic        capture_q;
	logic        cap_in_q;
	logic        crc_skip_q;
	logic        init_err_q;
	logic [31:0] prdata_d;
	logic        slverr_d;
	logic        access;
	cosc_src_t   src;

	function automatic logic [31:0] status_word(input logic [2:0] ph, input logic eos, input logic we,
		input logic ts, input logic rel, input logic keep);
		return {24'h0000_00, keep, rel, ph, eos, we, !ts};
	endfunction

	assign access  = psel && penable;
	assign pready  = 1'b1;

	// Writes take effect at the access edge; only writable bits are stored
	always_ff @(posedge mclk) begin
		if (reset) begin
			primary_q <= `COSC_PRIMARY_RESET;
		end else if (access && pwrite && paddr == `COSC_OFF_PRIMARY) begin
			primary_q <= pwdata & `COSC_PRIMARY_MASK;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			secondary_q <= `COSC_SECONDARY_RESET;
		end else if (access && pwrite && paddr == `COSC_OFF_SECONDARY) begin
			secondary_q <= pwdata & `COSC_SECONDARY_MASK;
		end
	end

	always_comb begin
		prdata_d = 32'h0000_0000;
		slverr_d = 1'b0;
		if (paddr == `COSC_OFF_PRIMARY) begin
			prdata_d = primary_q;
		end else if (paddr == `COSC_OFF_SECONDARY) begin
			prdata_d = secondary_q;
		end else if (paddr == `COSC_OFF_CONTROL) begin
			prdata_d = {31'h0000_0000, capture_armed_q};
		end else if (paddr == `COSC_OFF_STATUS) begin
			prdata_d = status_word(sq.phase_gray, sq.end_of_startup, sq.write_enable,
				sq.io_tristate, sq.done_release, keep_q);
		end else begin
			slverr_d = 1'b1;
		end
	end

	assign prdata  = prdata_d;
	assign pslverr = access && slverr_d;

	// RULE8
	always_comb begin
		if (primary_q[`COSC_SRC_HI]) begin
			src = COSC_SRC_TEST;
		end else if (primary_q[`COSC_SRC_LO]) begin
			src = COSC_SRC_USER;
		end else begin
			src = COSC_SRC_CONFIG;
		end
	end

	always_comb begin
		case (src)
			COSC_SRC_USER:   sq.step_en = fabric_user_clock_tick;
			COSC_SRC_TEST:   sq.step_en = test_port_clock_tick;
			default:         sq.step_en = config_clock_tick;
		endcase
	end

	assign sq.done_code      = primary_q[`COSC_DONE_LO +: 3];
	assign sq.match_code     = primary_q[`COSC_MATCH_LO +: 3];
	assign sq.lock_code      = primary_q[`COSC_LOCK_LO +: 3];
	assign sq.gts_code       = primary_q[`COSC_GTS_LO +: 3];
	assign sq.gwe_code       = primary_q[`COSC_GWE_LO +: 3];
	assign sq.done_pipe      = primary_q[`COSC_BIT_DONE_PIPE];
	assign sq.finished_input = finished_pin_in;
	assign sq.match_ok       = &impedance_calibration_match; // RULE10
	assign sq.lock_ok        = &clock_manager_lock; // RULE19

	cosc_sequencer u_seq (
		.mclk  (mclk),
		.reset (reset),
		.sq    (sq)
	);

	// Sleep select hands the pin to the status signal; drive bit picks push-pull or open drain
	always_comb begin
		if (primary_q[`COSC_BIT_SLEEP_SEL]) begin
			finished_pin_out = 1'b1; // RULE2
			finished_pin_oe  = 1'b1;
		end else if (primary_q[`COSC_BIT_DRIVE_DONE]) begin
			finished_pin_out = sq.done_release; // RULE4
			finished_pin_oe  = 1'b1;
		end else begin
			finished_pin_out = 1'b0; // RULE4
			finished_pin_oe  = !sq.done_release;
		end
	end

	assign global_io_tristate  = sq.io_tristate; // RULE21
	assign global_write_enable = sq.write_enable; // RULE20
	assign startup_phase       = sq.phase_gray;

	// RULE1
	always_ff @(posedge mclk) begin
		if (reset) begin
			crc_skip_q <= 1'b0;
		end else if (crc_check_valid) begin
			crc_skip_q <= primary_q[`COSC_BIT_CRC_BYPASS] && crc_check_value == `COSC_CRC_SPECIAL;
		end
	end
	assign crc_check_skip = crc_skip_q;

	// A reset command re-arms even if a capture lands in the same cycle, so it is never lost
	always_ff @(posedge mclk) begin
		if (reset) begin
			capture_armed_q <= 1'b1;
		end else if (readback_capture_reset_command) begin
			capture_armed_q <= 1'b1; // RULE6
		end else if (capture_q && primary_q[`COSC_BIT_SINGLE]) begin
			capture_armed_q <= 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			cap_in_q  <= 1'b0;
			capture_q <= 1'b0;
		end else begin
			cap_in_q  <= capture_input;
			// RULE5
			capture_q <= ((capture_input && !cap_in_q) || global_capture_command) &&
				(!primary_q[`COSC_BIT_SINGLE] || capture_armed_q);
		end
	end
	assign capture_strobe = capture_q;

	// RULE15
	always_ff @(posedge mclk) begin
		if (reset) begin
			init_err_q <= 1'b0;
		end else begin
			init_err_q <= secondary_q[`COSC_BIT_RB_EN] && !secondary_q[`COSC_BIT_RB_NOPIN] && readback_check_error;
		end
	end
	assign readback_check_run = secondary_q[`COSC_BIT_RB_EN];
	assign init_pin_error     = init_err_q;

	// RULE14
	always_ff @(posedge mclk) begin
		if (reset) begin
			keep_q <= 1'b1;
		end else if (unsync_command && secondary_q[`COSC_BIT_KEEP_REL]) begin
			keep_q <= 1'b0;
		end
	end
	assign config_port_keep = keep_q;

	assign osc_frequency_select    = primary_q[`COSC_OSC_HI:`COSC_OSC_LO]; // RULE7
	assign flash_first_read_clocks = {1'b0, secondary_q[`COSC_FLASH_RD_LO +: 2]} + 3'd1; // RULE16
	// RULE17
	always_comb begin
		case (secondary_q[`COSC_FLASH_PG_LO +: 2])
			2'b00:   flash_page_length = 4'd1;
			2'b01:   flash_page_length = 4'd4;
			2'b10:   flash_page_length = 4'd8;
			default: flash_page_length = 4'd1;
		endcase
	end
	assign flash_page_reserved = secondary_q[`COSC_FLASH_PG_LO +: 2] == 2'b11;

	a_crc_bypass: assert property (@(posedge mclk) disable iff (reset) // RULE1
		(crc_check_valid && crc_check_value == 16'hDEFC && primary_q[28]) |=> crc_check_skip)
		else $error("special value did not bypass check");
	a_single_block: assert property (@(posedge mclk) disable iff (reset) // RULE6
		(primary_q[23] && !capture_armed_q && !readback_capture_reset_command) |=> !capture_strobe)
		else $error("single-shot capture repeated without reset command");
	a_keep_release: assert property (@(posedge mclk) disable iff (reset) // RULE14
		(unsync_command && secondary_q[17]) |=> !config_port_keep)
		else $error("keep not released on unsync");
	a_nopin_quiet: assert property (@(posedge mclk) disable iff (reset) // RULE15
		secondary_q[9] |=> !init_pin_error)
		else $error("init pin reported with no-pin set");
endmodule

// ---- sim/cosc_host_model.sv ----
// Configuration host model: APB master that writes and reads the option words
`timescale 1ns/1ps
module cosc_host_model (
	// Clock
	input  wire logic        mclk,
	// APB master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr
);
	initial begin
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
	end

	// Request held until pready is seen high at a rising edge, then released
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge mclk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do @(posedge mclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ---- sim/config_option_startup_control_tb_top.sv ----
// Self-checking bench for the startup option registers and sequencer
`timescale 1ns/1ps
module config_option_startup_control_tb_top;
	typedef struct {
		logic [11:0] a;
		logic [31:0] wd;
		logic [31:0] rx;
		logic        ex;
		logic [2:0]  fr;
		logic [3:0]  pg;
	} cosc_row_t;
	logic        mclk  = 1'b0;
	logic        reset = 1'b1;
	logic [6:0]  pl    = 7'h00;
	logic [3:0]  lock  = 4'h7;
	logic [3:0]  impedance_calibration   = 4'hF;
	logic        fin   = 1'b1;
	logic        cap   = 1'b0;
	logic        rberr = 1'b0;
	logic [15:0] crcv  = 16'h0000;
	logic        psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        tri_s, we, fpo, fpoe, skip, strobe, run, initerr, keep, pres;
	logic [2:0]  phase, frc;
	logic [5:0]  osc;
	logic [3:0]  pgl;
	int          fail_count = 0;
	int          cmp_count  = 0;
	int          strobes    = 0;
	logic [2:0]  gray [8]   = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h6, 3'h7, 3'h5, 3'h4};
	cosc_row_t   rows [5]   = '{
		'{12'h004, 32'h0000_0000, 32'h0000_0000, 1'b0, 3'h1, 4'h1},
		'{12'h004, 32'h0000_0005, 32'h0000_0005, 1'b0, 3'h2, 4'h4},
		'{12'h004, 32'h0000_000A, 32'h0000_000A, 1'b0, 3'h3, 4'h8},
		'{12'h004, 32'hFFFF_FFFF, 32'h0002_030F, 1'b0, 3'h4, 4'h1},
		'{12'h010, 32'h1234_5678, 32'h0000_0000, 1'b1, 3'h4, 4'h1}};

	always #2 mclk = ~mclk;
	always @(posedge mclk) if (strobe === 1'b1) strobes++;

	cosc_host_model i_cosc_host_model (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));

	cosc_startup_options #(.NUM_CLOCK_MANAGERS(4), .NUM_IO_BANKS(4)) i_cosc_startup_options (
		.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.config_clock_tick(pl[0]), .fabric_user_clock_tick(pl[1]), .test_port_clock_tick(pl[2]),
		.impedance_calibration_match(impedance_calibration), .clock_manager_lock(lock), .finished_pin_in(fin),
		.finished_pin_out(fpo), .finished_pin_oe(fpoe), .global_io_tristate(tri_s),
		.global_write_enable(we), .startup_phase(phase), .crc_check_valid(pl[6]),
		.crc_check_value(crcv), .crc_check_skip(skip), .capture_input(cap),
		.global_capture_command(pl[3]), .readback_capture_reset_command(pl[4]),
		.capture_strobe(strobe), .readback_check_error(rberr), .readback_check_run(run),
		.init_pin_error(initerr), .unsync_command(pl[5]), .config_port_keep(keep),
		.osc_frequency_select(osc), .flash_first_read_clocks(frc), .flash_page_length(pgl),
		.flash_page_reserved(pres));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		i_cosc_host_model.xfer(1'b1, a, d, rd, err);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] e);
		i_cosc_host_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
		chk(rd, e);
	endtask

	// One-cycle pulse on one event input, then let the result settle
	task automatic pulse(input int b);
		@(posedge mclk);
		pl[b] <= 1'b1;
		@(posedge mclk);
		pl <= 7'h00;
		repeat (2) @(posedge mclk);
		#1;
	endtask

	task automatic do_reset();
		@(posedge mclk);
		reset <= 1'b1;
		repeat (8) @(posedge mclk);
		reset <= 1'b0;
		#1;
	endtask

	task automatic print_verdict();
		$display("fail_count=%0d cmp_count=%0d", fail_count, cmp_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		print_verdict();
	end

	initial begin
		do_reset();
		rdc(12'h000, 32'h0000_3FEC);
		rdc(12'h004, 32'h0000_0000);
		chk({29'h0, tri_s, we, keep}, 32'h5);
		foreach (rows[i]) begin
			i_cosc_host_model.xfer(1'b1, rows[i].a, rows[i].wd, rd, err);
			chk({31'h0, err}, {31'h0, rows[i].ex});
			rdc(rows[i].a, rows[i].rx);
			chk({28'h0, pgl}, {28'h0, rows[i].pg});
			chk({29'h0, frc}, {29'h0, rows[i].fr});
		end
		chk({31'h0, pres}, 32'h1);
		wr(12'h000, 32'hFFFF_FFFF);
		rdc(12'h000, 32'h1BFF_FFFF);
		chk({26'h0, osc}, 32'h3F);
		chk({30'h0, fpo, fpoe}, 32'h3);
		// Lock stalls at phase 2 while one clock manager is unlocked
		do_reset();
		wr(12'h000, 32'h0000_2E81);
		for (int i = 1; i <= 6; i++) begin
			pulse(0);
			chk({29'h0, phase}, {29'h0, gray[(i > 2) ? 2 : i]});
		end
		chk({30'h0, tri_s, we}, 32'h1);
		chk({30'h0, fpo, fpoe}, 32'h1);
		@(posedge mclk);
		lock <= 4'hF;
		for (int i = 3; i <= 8; i++) begin
			pulse(0);
			chk({29'h0, phase}, {29'h0, gray[(i > 7) ? 7 : i]});
		end
		chk({31'h0, fpoe}, 32'h0);
		// Match stall, then the pipelined finished input holds the sequencer after its release
		do_reset();
		chk({29'h0, phase}, 32'h0);
		@(posedge mclk);
		impedance_calibration <= 4'hE;
		wr(12'h000, 32'h0200_23F6);
		pulse(0);
		pulse(0);
		chk({29'h0, phase}, 32'h1);
		rdc(12'h00C, 32'h0000_008B);
		rdc(12'h008, 32'h0000_0001);
		@(posedge mclk);
		impedance_calibration <= 4'hF;
		fin <= 1'b0;
		repeat (3) pulse(0);
		chk({29'h0, phase}, 32'h2);
		@(posedge mclk);
		fin <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk({30'h0, tri_s, we}, 32'h2);
		pulse(0);
		chk({27'h0, phase, tri_s, we}, 32'h9);
		pulse(0);
		chk({29'h0, phase}, 32'h6);
		// Without the pipeline stage three-state and write enable follow the pin at once
		wr(12'h000, 32'h0000_23F6);
		@(posedge mclk);
		fin <= 1'b0;
		@(posedge mclk);
		#1;
		chk({30'h0, tri_s, we}, 32'h2);
		@(posedge mclk);
		fin <= 1'b1;
		// Clock source selection, with three-state kept
		do_reset();
		wr(12'h000, 32'h0000_BFFC);
		pulse(0);
		chk({29'h0, phase}, 32'h0);
		pulse(1);
		chk({29'h0, phase}, 32'h1);
		wr(12'h000, 32'h0001_3FFC);
		pulse(1);
		pulse(2);
		chk({29'h0, phase}, 32'h3);
		chk({31'h0, tri_s}, 32'h1);
		// CRC bypass on the special value
		@(posedge mclk);
		crcv <= 16'hDEFC;
		pulse(6);
		chk({31'h0, skip}, 32'h0);
		wr(12'h000, 32'h1000_3FEC);
		pulse(6);
		chk({31'h0, skip}, 32'h1);
		// Capture in repeat mode, then in single-shot mode
		strobes = 0;
		pulse(3);
		@(posedge mclk);
		cap <= 1'b1;
		repeat (4) @(posedge mclk);
		cap <= 1'b0;
		#1;
		chk(strobes, 32'd2);
		wr(12'h000, 32'h1080_3FEC);
		pulse(4);
		pulse(3);
		pulse(3);
		chk(strobes, 32'd3);
		pulse(4);
		pulse(3);
		chk(strobes, 32'd4);
		// Readback check reporting and keep release
		wr(12'h004, 32'h0002_0300);
		@(posedge mclk);
		rberr <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk({30'h0, run, initerr}, 32'h2);
		wr(12'h004, 32'h0002_0100);
		repeat (3) @(posedge mclk);
		#1;
		chk({30'h0, run, initerr}, 32'h3);
		pulse(5);
		chk({31'h0, keep}, 32'h0);
		print_verdict();
	end
endmodule
